//--- common/dba_pkg.sv
// dba_pkg: constants for the bank/burst access block.
// assumes one sys_clk domain; data pins modelled as two words per clock.
package dba_pkg;
  localparam int BANK_GROUPS     = 4;      // bank groups
  localparam int BANKS_PER_GROUP = 4;      // banks in each group
  localparam int NUM_BANKS       = 16;     // total banks
  localparam int ROW_W           = 15;     // row address lines
  localparam int COL_W           = 10;     // column bits
  localparam int BG_W            = 2;      // bank group select width
  localparam int BA_W            = 2;      // bank select width
  localparam int BEATS_FULL      = 8;      // full eight beat burst
  localparam int BEATS_CHOP      = 4;      // chopped four beat burst
  localparam int CORE_CLOCKS     = 4;      // core transfer clocks
  localparam int CRC_ALERT_NS    = 100;    // crc alert pulse time
  localparam int CLK_NS          = 10;     // sys_clk period
  localparam int CRC_ALERT_CYC   = (CRC_ALERT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAR_RECOV_CYC   = 64;     // parity recovery cycles
  localparam logic [2:0] CMD_NOP = 3'h0;   // command codes
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_RD  = 3'h2;
  localparam logic [2:0] CMD_WR  = 3'h3;
  typedef enum logic [2:0] {
    DBA_IDLE  = 3'h1,
    DBA_BURST = 3'h2,
    DBA_ERR   = 3'h4
  } dba_state_t;
endpackage : dba_pkg

//--- verilog/dba_core.sv
// dba_core: bank table, burst engine and error alert of the dram device.
// assumes the controller initialises the part and activates before access.
// Behaviour
// - crc error: alert low fixed time
// - parity error: alert low until recovery
// - sixteen banks, four groups of four
// - one core transfer over four clocks
// - two data words per clock
// - bursts of eight or chopped four
// - activate takes group, bank, row
// - read/write address gives starting column
// - autoprecharge flag closes bank after access
// - burst chop low selects four beats when on-the-fly chop (otf_enable) is on
`timescale 1ns/1ns
module dba_core
  import dba_pkg::*;
#(
  parameter int W = 8  // n, data word width
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [2:0]        cmd,
  input  wire logic [BG_W-1:0]   bank_group_select,
  input  wire logic [BA_W-1:0]   bank_select,
  input  wire logic [ROW_W-1:0]  row_address_lines,
  input  wire logic              autoprecharge_flag,
  input  wire logic              burst_chop_n,
  input  wire logic              otf_enable,
  input  wire logic              crc_error,
  input  wire logic              parity_error,
  input  wire logic [2*W-1:0]    wr_data,
  output logic                   alert_n,
  output logic [2*W-1:0]         rd_data,
  output logic                   rd_valid,
  output logic                   wr_take,
  output logic [COL_W-1:0]       beat_col,
  output logic [NUM_BANKS-1:0]   bank_open,
  output logic                   cmd_error
);
  ////////////////////////////////////////////////////////////////////////
  // bank index from group and bank selects
  // sixteen banks, four groups
  function automatic logic [3:0] bank_idx(input logic [1:0] g, input logic [1:0] b);
    bank_idx = {g, b};
  endfunction : bank_idx

  dba_state_t          state;       // burst engine state
  logic [ROW_W-1:0]    open_row [NUM_BANKS];  // row held open per bank
  logic [3:0]          cur_bank;    // bank in the running burst
  logic                cur_ap;      // precharge when burst ends
  logic                cur_wr;      // burst direction
  logic [COL_W-1:0]    col_base;    // starting column
  logic [2:0]          pairs_left;  // clocks left, two beats each
  logic [1:0]          pair_cnt;    // pair index within the burst
  logic [2*W-1:0]      mem [NUM_BANKS*4];  // small per-bank store
  logic [7:0]          alert_cnt;   // alert low countdown
  logic [3:0]          idx;
  logic                start;

  assign idx   = bank_idx(bank_group_select, bank_select);
  // access only to an open bank
  assign start = (state == DBA_IDLE) && (cmd == CMD_RD || cmd == CMD_WR) && bank_open[idx];

  ////////////////////////////////////////////////////////////////////////
  // bank table
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bank_open <= '0;
    end else begin
      if (cmd == CMD_ACT && state == DBA_IDLE) begin
        bank_open[idx] <= 1'b1;
        open_row[idx]  <= row_address_lines;
      end
      if (state == DBA_BURST && pairs_left == 3'h1 && cur_ap) begin
        bank_open[cur_bank] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst engine; address bits above COL_W are ignored as column
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= DBA_IDLE;
      cur_bank   <= 4'h0;
      cur_ap     <= 1'b0;
      cur_wr     <= 1'b0;
      col_base   <= '0;
      pairs_left <= 3'h0;
      pair_cnt   <= 2'h0;
      cmd_error  <= 1'b0;
    end else begin
      cmd_error <= (cmd == CMD_RD || cmd == CMD_WR) && !start;
      case (state)
        DBA_IDLE: begin
          if (parity_error) begin
            state <= DBA_ERR;
          end else if (start) begin
            cur_bank <= idx;
            cur_ap   <= autoprecharge_flag;
            cur_wr   <= (cmd == CMD_WR);
            col_base <= row_address_lines[COL_W-1:0];
            pair_cnt <= 2'h0;
            // low chop line gives four beats only while otf_enable is set
            pairs_left <= (otf_enable && !burst_chop_n) ? 3'(BEATS_CHOP/2)
                                                        : 3'(BEATS_FULL/2);
            state <= DBA_BURST;
          end
        end
        DBA_BURST: begin
          pairs_left <= pairs_left - 3'h1;
          pair_cnt   <= pair_cnt + 2'h1;
          if (pairs_left == 3'h1) begin
            state <= DBA_IDLE;
          end
        end
        DBA_ERR: begin
          if (alert_cnt == 8'h1) begin
            state <= DBA_IDLE;
          end
        end
        default: state <= DBA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data path: two words a clock; core word of 8n spans four clocks
  logic [2:0] pair_no;
  // counts up from the first pair, so a chopped burst starts at its column too
  assign pair_no = {1'b0, pair_cnt};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      wr_take  <= 1'b0;
      rd_data  <= '0;
      beat_col <= '0;
    end else begin
      rd_valid <= (state == DBA_BURST) && !cur_wr;
      wr_take  <= (state == DBA_BURST) && cur_wr;
      beat_col <= col_base + COL_W'({pair_no[1:0], 1'b0});
      if (state == DBA_BURST) begin
        if (cur_wr) begin
          mem[{cur_bank, pair_no[1:0]}] <= wr_data;
        end else begin
          rd_data <= mem[{cur_bank, pair_no[1:0]}];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error alert; parity outranks crc since recovery is longer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alert_cnt <= 8'h0;
      alert_n   <= 1'b1;
    end else begin
      if (parity_error) begin
        alert_cnt <= 8'(PAR_RECOV_CYC);
        alert_n   <= 1'b0;
      end else if (crc_error && alert_cnt == 8'h0) begin
        alert_cnt <= 8'(CRC_ALERT_CYC);
        alert_n   <= 1'b0;
      end else if (alert_cnt != 8'h0) begin
        alert_cnt <= alert_cnt - 8'h1;
        alert_n   <= (alert_cnt == 8'h1);
      end else begin
        alert_n <= 1'b1;
      end
    end
  end

  property p_crc_pulse;
    @(posedge sys_clk) disable iff (rst)
      (crc_error && !parity_error && alert_cnt == 8'h0 && alert_n) |=> !alert_n [*8] ##0 1;
  endproperty
  a_crc_pulse: assert property (p_crc_pulse) else $error("crc alert too short");

  property p_par_hold;
    @(posedge sys_clk) disable iff (rst)
      parity_error |=> (!alert_n && state == DBA_ERR) [*8];
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parity alert dropped");

  property p_idle_high;
    @(posedge sys_clk) disable iff (rst)
      (alert_cnt == 8'h0 && !crc_error && !parity_error) |=> alert_n;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("alert low with no error");

  property p_burst_len;
    @(posedge sys_clk) disable iff (rst)
      (start && !parity_error && !(otf_enable && !burst_chop_n)) |=>
        (state == DBA_BURST) [*4] ##1 (state == DBA_IDLE);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("full burst length wrong");

  property p_chop_len;
    @(posedge sys_clk) disable iff (rst)
      (start && !parity_error && otf_enable && !burst_chop_n) |=>
        (state == DBA_BURST) [*2] ##1 (state == DBA_IDLE);
  endproperty
  a_chop_len: assert property (p_chop_len) else $error("chopped burst length wrong");

  property p_act_open;
    @(posedge sys_clk) disable iff (rst)
      (cmd == CMD_ACT && state == DBA_IDLE) |=> bank_open[$past(idx)];
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate did not open bank");

  property p_act_row;
    @(posedge sys_clk) disable iff (rst)
      (cmd == CMD_ACT && state == DBA_IDLE) |=>
        (open_row[$past(idx)] == $past(row_address_lines));
  endproperty
  a_act_row: assert property (p_act_row) else $error("activate row not held");

  property p_ap_close;
    @(posedge sys_clk) disable iff (rst)
      (state == DBA_BURST && pairs_left == 3'h1 && cur_ap) |=> !bank_open[$past(cur_bank)];
  endproperty
  a_ap_close: assert property (p_ap_close) else $error("autoprecharge left bank open");

  property p_rd_pairs;
    @(posedge sys_clk) disable iff (rst)
      (start && !parity_error && cmd == CMD_RD && !(otf_enable && !burst_chop_n)) |=>
        ##1 rd_valid [*4];
  endproperty
  a_rd_pairs: assert property (p_rd_pairs) else $error("read not four clocks");
endmodule : dba_core

//--- test/dba_ctrl_model.sv
// dba_ctrl_model: controller side driving commands and write pairs.
// assumes the bench calls op once the device is out of reset.
`timescale 1ns/1ns
module dba_ctrl_model
  import dba_pkg::*;
(
  input  wire logic             sys_clk,
  output logic [2:0]            cmd,
  output logic [BG_W-1:0]       bank_group_select,
  output logic [BA_W-1:0]       bank_select,
  output logic [ROW_W-1:0]      row_address_lines,
  output logic                  autoprecharge_flag,
  output logic                  burst_chop_n,
  output logic [15:0]           wr_data
);
  initial begin
    cmd = CMD_NOP;
    {bank_group_select, bank_select, row_address_lines} = '0;
    {autoprecharge_flag, burst_chop_n} = 2'h1;
    wr_data = 16'h0;
  end
  // pairs follow from the edge after the command
  // released data bus shows the inverse, not the last pair
  task op(input logic [2:0] c, input logic [3:0] bk, input logic [14:0] ra,
          input logic ap, input logic bcn, input logic [63:0] d);
    @(posedge sys_clk);
    cmd <= c;
    {bank_group_select, bank_select} <= bk;
    row_address_lines <= ra;
    autoprecharge_flag <= ap;
    burst_chop_n <= bcn;
    @(posedge sys_clk);
    cmd <= CMD_NOP;
    wr_data <= d[15:0];
    @(posedge sys_clk);
    wr_data <= d[31:16];
    @(posedge sys_clk);
    wr_data <= d[47:32];
    @(posedge sys_clk);
    wr_data <= d[63:48];
    @(posedge sys_clk);
    wr_data <= ~d[63:48];
    repeat (3) @(posedge sys_clk);
  endtask : op
endmodule : dba_ctrl_model

//--- test/dba_core_tb.sv
// dba_core_tb: bursts, chop, autoprecharge, refusal and alert timing.
// assumes the package constants and a 100 MHz sys_clk.
`timescale 1ns/1ns
module dba_core_tb;
  import dba_pkg::*;
  logic sys_clk = 0, rst = 1, otf_enable = 0, crc_error = 0, parity_error = 0;
  logic [2:0]  cmd;
  logic [1:0]  bg, ba;
  logic [14:0] row;
  logic        ap, bcn, alert_n, rd_valid, wr_take, cmd_error;
  logic [15:0] wr_data, rd_data, bank_open;
  logic [63:0] d;
  logic [3:0]  bk;
  logic [15:0] exp_q[$];
  logic [15:0] exp_c[$];
  logic [9:0]  col, beat_col;
  int miscompares = 0, checked = 0, seed = 76, errs = 0, takes = 0;
  dba_ctrl_model ctl (.sys_clk(sys_clk), .cmd(cmd), .bank_group_select(bg),
    .bank_select(ba), .row_address_lines(row), .autoprecharge_flag(ap),
    .burst_chop_n(bcn), .wr_data(wr_data));
  dba_core DUT (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .bank_group_select(bg),
    .bank_select(ba), .row_address_lines(row), .autoprecharge_flag(ap),
    .burst_chop_n(bcn), .otf_enable(otf_enable), .crc_error(crc_error),
    .parity_error(parity_error), .wr_data(wr_data), .alert_n(alert_n),
    .rd_data(rd_data), .rd_valid(rd_valid), .wr_take(wr_take), .beat_col(beat_col),
    .bank_open(bank_open), .cmd_error(cmd_error));
  initial forever #5 sys_clk = ~sys_clk;
  task end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task cmp_v(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp_v
  task cmp_n(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      miscompares++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask : cmp_n
  // notes the pairs and columns of one read burst, from the starting column
  task note_rd(input int pairs);
    exp_q = {};
    exp_c = {};
    for (int k = 0; k < pairs; k++) begin
      exp_q.push_back(d[16*k +: 16]);
      exp_c.push_back({6'h0, col + 10'(2*k)});
    end
  endtask : note_rd
  // count low cycles of the alert, bounded; starts in the edge that pulled it low
  task alert_low(input int e);
    int n;
    int i;
    n = 0;
    for (i = 0; i < 300; i++) begin
      #1;
      if (alert_n === 1'b0) n++;
      else if (n > 0) break;
      @(posedge sys_clk);
    end
    if (i == 300) begin
      miscompares++;
      end_sim;
    end else begin
      cmp_n("alert_low", e, n);
    end
  endtask : alert_low
  // oldest note against each read pair
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      cmp_v("rd_data", exp_q.size() ? exp_q.pop_front() : ~rd_data, rd_data);
      cmp_v("beat_col", exp_c.size() ? exp_c.pop_front() : 16'hFFFF, {6'h0, beat_col});
    end
    if (cmd_error === 1'b1) errs++;
    if (wr_take === 1'b1) takes++;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    #1 cmp_v("alert_n", 16'h1, {15'h0, alert_n});
    bk = 4'($random(seed));
    col = 10'($random(seed));
    d = {$random(seed), $random(seed)};
    ctl.op(CMD_ACT, bk, 15'($random(seed)), 1'h0, 1'h1, d);
    cmp_v("bank_open", 16'h1 << bk, bank_open);
    ctl.op(CMD_WR, bk, {5'h0, col}, 1'h0, 1'h1, d);
    cmp_n("wr_take", 4, takes);
    // chop line low while on-the-fly chop is off: still eight beats
    note_rd(4);
    ctl.op(CMD_RD, bk, {5'h0, col}, 1'h0, 1'h0, d);
    cmp_n("full_left", 0, exp_q.size());
    otf_enable <= 1'h1;
    note_rd(2);
    ctl.op(CMD_RD, bk, {5'h0, col}, 1'h0, 1'h0, d);
    cmp_n("chop_left", 0, exp_q.size());
    note_rd(4);
    ctl.op(CMD_RD, bk, {5'h0, col}, 1'h1, 1'h1, d);
    cmp_v("bank_open", 16'h0, bank_open);
    ctl.op(CMD_RD, bk, {5'h0, col}, 1'h0, 1'h1, d);
    cmp_n("cmd_error", 1, errs);
    cmp_n("rd_left", 0, exp_q.size());
    crc_error <= 1'h1;
    @(posedge sys_clk);
    crc_error <= 1'h0;
    alert_low(CRC_ALERT_CYC);
    @(posedge sys_clk);
    parity_error <= 1'h1;
    @(posedge sys_clk);
    parity_error <= 1'h0;
    alert_low(PAR_RECOV_CYC);
    end_sim;
  end
endmodule : dba_core_tb
